//--- design/aop_port.sv
// output port mode selection and pin sharing for a 16-bit converter
// assumes result and convBusy come from logic on mclk; mode pins are
// asynchronous levels; sclkIn is the host clock in slave serial mode
//
// What this block does
// - swap input exchanges high and low bus bytes
// - low format input inverts the result MSB
// - port select chooses parallel bus or serial port
// - serial mode floats data bits zero and one
// - bits two, three: data or clock slowdown
// - clock source: internal driven or host supplied
// - frame polarity input sets frame active level
// - clock invert input flips serial clock both modes
// - parallel mode drives bits four to six
// - divider codes set 25/50/100/200 ns minimum periods; at 10 MHz all four round up to 200 ns
// - read mode: during or after conversion
// - serial result shifts out MSB first
module aop_port
    import aop_pkg::*;
#(
    parameter int W = RES_W
) (
    // clocks and reset
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         sclkIn,
    // conversion core side
    input  wire logic [W-1:0] result,
    input  wire logic         resultDone,
    input  wire logic         convBusy,
    // dedicated mode pins
    input  wire logic         portTypeSelect,
    input  wire logic         halfOrderSwap,
    input  wire logic         outputCodeFormat,
    // shared pins read as serial configuration
    input  wire logic [7:2]   cfgPinIn,
    // shared data bus pins
    output logic      [W-1:0] dataOut,
    output logic      [W-1:0] dataOe_n
);

    // pin map and struct widths are fixed to a 16-bit word
    if (W != RES_W || W != 2 * BYTE_W) begin : g_bad_width
        $error("aop_port supports only a 16-bit result");
    end

    aop_mst_t q, d;
    aop_lnk_t l_q, l_d;

    aop_cfg_t          cfgRaw;
    logic [W-1:0]      fmtNew;
    logic              master;
    logic              slave;
    logic              trig;
    logic [1:0]        divSel;
    logic [HALF_W-1:0] reload;
    logic              linkClk;

    // raw configuration levels, synchronised below
    assign cfgRaw = '{
        portSer:      portTypeSelect,
        swap:         halfOrderSwap,
        codeStraight: outputCodeFormat,
        clkExt:       cfgPinIn[PIN_CLKSRC],
        frameInv:     cfgPinIn[PIN_FRMINV],
        sclkInv:      cfgPinIn[PIN_SCKINV],
        readDuring:   cfgPinIn[PIN_RDMODE],
        div:          {cfgPinIn[PIN_DIV1], cfgPinIn[PIN_DIV0]}
    };

    // output coding applied once, as the result is stored
    assign fmtNew = q.cfg2.codeStraight ? result
                                        : {~result[W-1], result[W-2:0]};

    assign master = q.cfg2.portSer & ~q.cfg2.clkExt;
    assign slave  = q.cfg2.portSer & q.cfg2.clkExt;

    // frame start: busy rise reads the previous word during conversion
    assign trig = q.cfg2.readDuring ? (convBusy & ~q.busyPrev)
                                    : resultDone;

    // divider pins only count in master read-after-convert
    assign divSel = (master && !q.cfg2.readDuring) ? q.cfg2.div : 2'b00;

    // half period reload per divider code
    always_comb begin
        unique case (divSel)
            2'b00: reload = HALF_RELOAD_0;
            2'b01: reload = HALF_RELOAD_1;
            2'b10: reload = HALF_RELOAD_2;
            2'b11: reload = HALF_RELOAD_3;
        endcase
    end

    // system clock next state
    always_comb begin
        d = q;
        d.cfg1 = cfgRaw;
        d.cfg2 = q.cfg1;
        d.busyPrev = convBusy;
        if (resultDone) begin
            d.word = fmtNew;
            d.loadTgl = ~q.loadTgl;
        end
        unique case (q.st)
            AOP_IDLE: begin
                if (master && trig) begin
                    d.st = AOP_SHIFT;
                    d.shift = (resultDone && !q.cfg2.readDuring) ? fmtNew : q.word;
                    d.bitCnt = BITS_PER_WORD;
                    d.halfCnt = reload;
                    d.phase = 1'b0;
                    d.frameAct = 1'b1;
                end
            end
            AOP_SHIFT: begin
                if (q.halfCnt != '0) begin
                    d.halfCnt = q.halfCnt - 1'b1;
                end else begin
                    d.halfCnt = reload;
                    d.phase = ~q.phase;
                    // next bit after each falling edge of the clock
                    if (q.phase) begin
                        d.shift = {q.shift[W-2:0], 1'b0};
                        d.bitCnt = q.bitCnt - 1'b1;
                        if (q.bitCnt == 5'h01) begin
                            d.st = AOP_IDLE;
                            d.frameAct = 1'b0;
                        end
                    end
                end
            end
        endcase
        // leaving master mode aborts a frame in flight
        if (!master) begin
            d.st = AOP_IDLE;
            d.frameAct = 1'b0;
            d.phase = 1'b0;
        end
        // pin drive from the next state so pins match state registers
        if (!d.cfg2.portSer) begin
            d.dOut = d.cfg2.swap ? {d.word[BYTE_W-1:0], d.word[W-1:BYTE_W]}
                                 : d.word;
            d.dOe_n = '0;
        end else begin
            d.dOut = '0;
            d.dOut[PIN_SDO] = d.shift[W-1];
            d.dOut[PIN_SCLK] = d.phase ^ d.cfg2.sclkInv;
            d.dOut[PIN_FRAME] = d.frameAct ^ d.cfg2.frameInv;
            // config inputs and unused bits float in serial mode
            d.dOe_n = '1;
            d.dOe_n[PIN_SDO] = 1'b0;
            d.dOe_n[PIN_FRAME] = 1'b0;
            d.dOe_n[PIN_SCLK] = d.cfg2.clkExt;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.dOe_n <= '1;
        end else begin
            q <= d;
        end
    end

    // slave side runs on the host clock, inverted as configured
    assign linkClk = sclkIn ^ q.cfg2.sclkInv;

    // link next state; word is stable two edges before the toggle lands
    always_comb begin
        l_d = l_q;
        l_d.tgl1 = q.loadTgl;
        l_d.tgl2 = l_q.tgl1;
        if (!l_q.act) begin
            if (l_q.tgl2 != l_q.seen) begin
                l_d.seen = l_q.tgl2;
                l_d.act = 1'b1;
                l_d.sdo = q.word[W-1];
                l_d.shift = {q.word[W-2:0], 1'b0};
                l_d.cnt = LINK_LAST_CNT;
            end
        end else if (l_q.cnt != '0) begin
            l_d.sdo = l_q.shift[W-1];
            l_d.shift = {l_q.shift[W-2:0], 1'b0};
            l_d.cnt = l_q.cnt - 1'b1;
        end else begin
            l_d.act = 1'b0;
        end
        // outside slave mode the link stays idle and seen follows tgl2, but only on link clock edges
        if (!slave) begin
            l_d.act = 1'b0;
            l_d.seen = l_q.tgl2;
        end
        l_d.frame = l_d.act;
    end

    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // slave data and frame come from link flops, all else from mclk flops
    always_comb begin
        dataOut = q.dOut;
        if (slave) begin
            dataOut[PIN_SDO] = l_q.sdo;
            // polarity applied here, so an idle link still follows the pin
            dataOut[PIN_FRAME] = l_q.frame ^ q.cfg2.frameInv;
        end
    end
    assign dataOe_n = q.dOe_n;

    // checks on the system clock side
    a_byte_order: assert property (@(posedge mclk) disable iff (!arst_n)
        (!q.cfg2.portSer && q.cfg2.swap) |->
        (dataOut == {q.word[BYTE_W-1:0], q.word[W-1:BYTE_W]}))
        else $error("swapped byte order wrong");
    a_code_twos: assert property (@(posedge mclk) disable iff (!arst_n)
        (resultDone && !q.cfg2.codeStraight) |=>
        (q.word == {~$past(result[W-1]), $past(result[W-2:0])}))
        else $error("twos complement coding wrong");
    a_par_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        ($past(arst_n) && !q.cfg2.portSer) |-> (dataOe_n == 16'h0000))
        else $error("parallel bus not fully driven");
    a_low_float: assert property (@(posedge mclk) disable iff (!arst_n)
        (q.cfg2.portSer) |-> (dataOe_n[1:0] == 2'h3))
        else $error("bits zero and one driven in serial mode");
    a_cfg_float: assert property (@(posedge mclk) disable iff (!arst_n)
        (q.cfg2.portSer) |-> (&dataOe_n[PIN_RDMODE:PIN_DIV0]))
        else $error("configuration pin driven in serial mode");
    a_div_ignore: assert property (@(posedge mclk) disable iff (!arst_n)
        (q.cfg2.readDuring || !master) |-> (reload == HALF_RELOAD_0))
        else $error("divider pins used outside read after convert");
    a_sclk_drive: assert property (@(posedge mclk) disable iff (!arst_n)
        q.cfg2.portSer |-> (dataOe_n[PIN_SCLK] == q.cfg2.clkExt))
        else $error("serial clock drive does not follow source select");
    a_sclk_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        (master && q.st == AOP_IDLE) |-> (dataOut[PIN_SCLK] == q.cfg2.sclkInv))
        else $error("idle serial clock level wrong");
    a_frame_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        (master && !q.frameAct) |-> (dataOut[PIN_FRAME] == q.cfg2.frameInv))
        else $error("inactive frame level wrong");
    a_read_start: assert property (@(posedge mclk) disable iff (!arst_n)
        (master && q.st == AOP_IDLE && trig && $stable(q.cfg2)) |=>
        (q.st == AOP_SHIFT && q.bitCnt == BITS_PER_WORD))
        else $error("serial read did not start");
    a_msb_first: assert property (@(posedge mclk) disable iff (!arst_n)
        (master && q.st == AOP_SHIFT) |-> (dataOut[PIN_SDO] == q.shift[W-1]))
        else $error("serial data not from shift register top");
    a_frame_len: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(q.frameAct) |-> q.frameAct [*8])
        else $error("master frame ended too early");

    // check on the link side
    a_link_len: assert property (@(posedge linkClk) disable iff (!arst_n)
        $rose(l_q.act) |-> l_q.act [*8])
        else $error("slave frame ended too early");

endmodule

//--- design/aop_pkg.sv
// shared constants and carriers for the converter output port block
// assumes a 10 MHz system clock and a 16-bit result word
package aop_pkg;

    // result word layout
    localparam int RES_W  = 16;
    localparam int BYTE_W = 8;
    localparam int CNT_W  = 5;
    localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
    localparam logic [CNT_W-1:0] LINK_LAST_CNT = 5'h0f;

    // system clock rate
    localparam int MCLK_MHZ = 10;

    // minimum internal serial clock periods per divider code, in ns
    localparam int SCLK_MIN_NS_0 = 25;
    localparam int SCLK_MIN_NS_1 = 50;
    localparam int SCLK_MIN_NS_2 = 100;
    localparam int SCLK_MIN_NS_3 = 200;

    // half period in mclk cycles, rounded up, never below one
    function automatic int halfCycles(input int ns);
        int c;
        c = (ns * MCLK_MHZ + 1999) / 2000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int HALF_W = 4;
    localparam logic [HALF_W-1:0] HALF_RELOAD_0 = HALF_W'(halfCycles(SCLK_MIN_NS_0) - 1);
    localparam logic [HALF_W-1:0] HALF_RELOAD_1 = HALF_W'(halfCycles(SCLK_MIN_NS_1) - 1);
    localparam logic [HALF_W-1:0] HALF_RELOAD_2 = HALF_W'(halfCycles(SCLK_MIN_NS_2) - 1);
    localparam logic [HALF_W-1:0] HALF_RELOAD_3 = HALF_W'(halfCycles(SCLK_MIN_NS_3) - 1);

    // positions of shared pins on the data bus
    localparam int PIN_DIV0    = 2;
    localparam int PIN_DIV1    = 3;
    localparam int PIN_CLKSRC  = 4;
    localparam int PIN_FRMINV  = 5;
    localparam int PIN_SCKINV  = 6;
    localparam int PIN_RDMODE  = 7;
    localparam int PIN_SDO     = 8;
    localparam int PIN_SCLK    = 9;
    localparam int PIN_FRAME   = 10;

    // synchronised configuration levels
    typedef struct packed {
        logic       portSer;
        logic       swap;
        logic       codeStraight;
        logic       clkExt;
        logic       frameInv;
        logic       sclkInv;
        logic       readDuring;
        logic [1:0] div;
    } aop_cfg_t;

    typedef enum logic [0:0] {
        AOP_IDLE  = 1'b0,
        AOP_SHIFT = 1'b1
    } aop_state_t;

    // system clock domain state
    typedef struct packed {
        aop_cfg_t          cfg1;
        aop_cfg_t          cfg2;
        logic [RES_W-1:0]  word;
        logic              loadTgl;
        logic              busyPrev;
        aop_state_t        st;
        logic [CNT_W-1:0]  bitCnt;
        logic [HALF_W-1:0] halfCnt;
        logic              phase;
        logic [RES_W-1:0]  shift;
        logic              frameAct;
        logic [RES_W-1:0]  dOut;
        logic [RES_W-1:0]  dOe_n;
    } aop_mst_t;

    // link clock domain state
    typedef struct packed {
        logic             tgl1;
        logic             tgl2;
        logic             seen;
        logic             act;
        logic [CNT_W-1:0] cnt;
        logic [RES_W-1:0] shift;
        logic             sdo;
        logic             frame;
    } aop_lnk_t;

endpackage

//--- tb/aop_host_model.sv
// host side model: supplies the serial clock in slave mode and captures the word
// assumes one frame per go pulse; the clock only runs inside a burst
module aop_host_model (
    // control from the bench
    input  wire logic        go,
    input  wire logic        inv,
    input  wire logic        frameInv,
    // serial pins of the device
    input  wire logic        sdo,
    input  wire logic        frame,
    // clock and capture
    output logic             sclkIn,
    output logic [15:0]      word,
    output logic [4:0]       bits
);
    timeunit 1ns;
    timeprecision 100ps;

    initial sclkIn = 1'b0;

    // burst long enough to cover the toggle sync plus 17 active edges
    always @(posedge go) begin
        bits = 5'h00;
        sclkIn = inv;
        repeat (24) begin
            #62.5 sclkIn = ~inv;
            #62.5 sclkIn = inv;
            // sample half a period after the device updated the data pin
            if (frame === ~frameInv) begin
                word = {word[14:0], sdo};
                bits = bits + 5'h01;
            end
        end
    end
endmodule

//--- tb/adc_output_port_mode_select_tb_top.sv
// self-checking bench for the output port mode logic
// assumes the host model on the serial pins; shared pins driven as config inputs
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin errCount++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module adc_output_port_mode_select_tb_top
    import aop_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic             mclk, arst_n, sclkIn, resultDone, convBusy, hostGo;
    logic             portTypeSelect, halfOrderSwap, outputCodeFormat, ext, rd, prevSck;
    logic [RES_W-1:0] result, dataOut, dataOe_n, r, expW, monWord, hostWord;
    logic [7:2]       cfgPinIn, cfg;
    logic [RES_W-1:0] expQ[$];
    logic [4:0]       hostBits, monBits;
    logic [31:0]      lfsrState;
    int               errCount, checksDone, cycles, frmCycles;

    aop_port #(.W(RES_W)) dut (.mclk(mclk), .arst_n(arst_n), .sclkIn(sclkIn),
        .result(result), .resultDone(resultDone), .convBusy(convBusy),
        .portTypeSelect(portTypeSelect), .halfOrderSwap(halfOrderSwap),
        .outputCodeFormat(outputCodeFormat), .cfgPinIn(cfgPinIn),
        .dataOut(dataOut), .dataOe_n(dataOe_n));

    aop_host_model host (.go(hostGo), .inv(cfgPinIn[6]), .frameInv(cfgPinIn[5]),
        .sdo(dataOut[8]), .frame(dataOut[10]), .sclkIn(sclkIn), .word(hostWord),
        .bits(hostBits));

    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic printVerdict();
        $display("errors %0d checks %0d", errCount, checksDone);
        if (errCount == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic setCfg(input logic ser, input logic sw, input logic fmt,
                          input logic [7:2] c);
        @(posedge mclk);
        portTypeSelect <= ser;
        halfOrderSwap <= sw;
        outputCodeFormat <= fmt;
        cfgPinIn <= c;
        repeat (5) @(posedge mclk);
        #1;
    endtask

    // random result, stored by the device on a one-cycle done pulse
    task automatic sendResult(input logic fmt);
        lfsrState = lfsrNext(lfsrState);
        r = lfsrState[15:0];
        expQ.push_back(fmt ? r : {~r[15], r[14:0]});
        @(posedge mclk);
        result <= r;
        resultDone <= 1'b1;
        @(posedge mclk);
        resultDone <= 1'b0;
    endtask

    always #50 mclk = ~mclk;

    // hang guard, well above the ~1600 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            errCount++;
            printVerdict();
        end
    end

    // master frame monitor: counts active frame cycles, samples on rising clock
    always @(posedge mclk) begin
        if (portTypeSelect === 1'b1 && dataOut[10] === ~cfgPinIn[5]) begin
            frmCycles++;
            if ((dataOut[9] ^ cfgPinIn[6]) && !prevSck) begin
                monWord = {monWord[14:0], dataOut[8]};
                monBits = monBits + 5'h01;
            end
        end
        prevSck = dataOut[9] ^ cfgPinIn[6];
    end

    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        {resultDone, convBusy, hostGo, portTypeSelect, halfOrderSwap} = '0;
        outputCodeFormat = 1'b0;
        result = '0;
        cfgPinIn = '0;
        lfsrState = 32'hfda4;
        repeat (5) @(posedge mclk);
        #1;
        `CHK("reset enables", 16'hffff, dataOe_n)
        @(posedge mclk);
        arst_n <= 1'b1;
        // parallel: every swap and format pair, config pins random and ignored
        for (int i = 0; i < 8; i++) begin
            setCfg(1'b0, i[0], i[1], lfsrState[5:0]);
            sendResult(i[1]);
            repeat (2) @(posedge mclk);
            #1;
            expW = expQ.pop_front();
            if (i[0])
                expW = {expW[7:0], expW[15:8]};
            `CHK("parallel word", expW, dataOut)
            `CHK("parallel enables", 16'h0000, dataOe_n)
        end
        // serial: master all dividers and polarities, slave, read during conversion
        for (int i = 0; i < 24; i++) begin
            ext = (i >= 16) && !i[2];
            rd = (i >= 16) && i[2];
            cfg = {rd, i[3] ^ i[0], i[2] ^ i[1], ext, i[1:0]};
            setCfg(1'b1, 1'b0, i[0], cfg);
            `CHK("serial enables", ext ? 16'hfaff : 16'hf8ff, dataOe_n)
            `CHK("frame idle", cfg[5], dataOut[10])
            if (!ext)
                `CHK("clock rest", cfg[6], dataOut[9])
            monBits = 5'h00;
            frmCycles = 0;
            // two dummy host reads drain link state left over from master mode
            if (i == 16) begin
                repeat (2) begin
                    @(posedge mclk);
                    hostGo <= 1'b1;
                    @(posedge mclk);
                    hostGo <= 1'b0;
                    repeat (35) @(posedge mclk);
                end
            end
            sendResult(i[0]);
            if (rd) begin
                repeat (40) @(posedge mclk);
                `CHK("no frame after done", 5'h00, monBits)
                convBusy <= 1'b1;
                repeat (2) @(posedge mclk);
                convBusy <= 1'b0;
            end
            if (ext) begin
                hostGo <= 1'b1;
                @(posedge mclk);
                hostGo <= 1'b0;
            end
            repeat (45) @(posedge mclk);
            #1;
            expW = expQ.pop_front();
            if (ext) begin
                `CHK("slave word", expW, hostWord)
                `CHK("slave bits", 5'h10, hostBits)
            end else begin
                `CHK("master word", expW, monWord)
                `CHK("master bits", 5'h10, monBits)
                `CHK("frame cycles", 32, frmCycles)
            end
        end
        printVerdict();
    end
endmodule
